// File: core/rsc_supervisor.v
// Rail monitor, thermal gate, interrupt logic and three converter controls
`timescale 1ns/10ps
`include "rsc_defs.vh"

module rsc_supervisor #(
   parameter [`RSC_SS_W-1:0] SS_CYCLES = `RSC_SS_CYC,
   parameter [`RSC_MS_W-1:0] MS_CYCLES = `RSC_MS_CYC
) (
   input wire sys_clk,
   input wire rst,
   // Analog comparator and pin inputs, asynchronous
   input wire sys_below_fall,
   input wire sys_above_rise,
   input wire temp_over,
   input wire temp_cooled,
   input wire lowbat_sense_in,
   input wire [`RSC_NBUCK-1:0] pg_ok,
   input wire output_bank_select,
   // Host control, already decoded from the serial port
   input wire sys_threshold_wr,
   input wire [3:0] sys_threshold_wdata,
   input wire sys_fault_response_wr,
   input wire sys_fault_response_wdata,
   input wire sys_level_irq_unmask,
   input wire sys_flag_rd,
   input wire [`RSC_NBUCK-1:0] buck_enable_bit,
   input wire [`RSC_NBUCK*`RSC_DCODE_W-1:0] buck_delay_code,
   input wire [`RSC_NBUCK-1:0] forced_pwm_wr,
   input wire forced_pwm_wdata,
   input wire [`RSC_NBUCK-1:0] vout_code_wr,
   input wire [`RSC_VCODE_W-1:0] vout_code_wdata,
   input wire [`RSC_NBUCK-1:0] fault_irq_unmask,
   input wire [`RSC_NBUCK-1:0] pg_rd,
   // Status and control outputs
   output reg [3:0] sys_threshold_sel,
   output reg sys_fault_response,
   output reg sys_under_flag,
   output reg power_ready,
   output reg thermal_lock,
   output reg [`RSC_NBUCK-1:0] pg_status,
   output reg [`RSC_NBUCK-1:0] forced_pwm,
   output reg [`RSC_NBUCK*`RSC_VCODE_W-1:0] buck_vout_code,
   output reg [`RSC_NBUCK-1:0] buck_run,
   output reg [`RSC_NBUCK-1:0] buck_soft_start,
   output reg int_request_n_out,
   output reg int_request_n_oe,
   output reg lowbat_flag_out_n_out,
   output reg lowbat_flag_out_n_oe
);

   localparam VW = `RSC_VCODE_W;
   localparam DW = `RSC_DCODE_W;

   // ==========================================================
   // Input synchronisers
   reg [`RSC_NSYNC-1:0] sync_meta;
   reg [`RSC_NSYNC-1:0] sync_q;
   wire below_s;
   wire rise_s;
   wire hot_s;
   wire cool_s;
   wire lowbat_s;
   wire [`RSC_NBUCK-1:0] pg_s;
   wire bank_s;

   always @(posedge sys_clk) begin
      if (rst) begin
         sync_meta <= {`RSC_NSYNC{1'b0}};
         sync_q <= {`RSC_NSYNC{1'b0}};
      end else begin
         sync_meta <= {output_bank_select, pg_ok, lowbat_sense_in,
                       temp_cooled, temp_over, sys_above_rise,
                       sys_below_fall};
         sync_q <= sync_meta;
      end
   end

   assign below_s = sync_q[0];
   assign rise_s = sync_q[1];
   assign hot_s = sync_q[2];
   assign cool_s = sync_q[3];
   assign lowbat_s = sync_q[4];
   assign pg_s = sync_q[7:5];
   assign bank_s = sync_q[8 + `RSC_NBUCK - 3];

   // ==========================================================
   // Millisecond tick for the turn-on delays
   reg [`RSC_MS_W-1:0] ms_cnt;
   reg ms_tick;

   always @(posedge sys_clk) begin
      if (rst) begin
         ms_cnt <= {`RSC_MS_W{1'b0}};
         ms_tick <= 1'b0;
      end else if (ms_cnt == MS_CYCLES - {{(`RSC_MS_W-1){1'b0}}, 1'b1}) begin
         ms_cnt <= {`RSC_MS_W{1'b0}};
         ms_tick <= 1'b1;
      end else begin
         ms_cnt <= ms_cnt + {{(`RSC_MS_W-1){1'b0}}, 1'b1};
         ms_tick <= 1'b0;
      end
   end

   // ==========================================================
   // System rail monitor
   // The comparators are analog; this logic only steers their threshold
   // code and holds the hysteresis state between the two trip points.
   reg next_under;
   wire fall_event;

   always @* begin
      next_under = sys_under_flag;
      if (below_s)
         next_under = 1'b1;
      else if (rise_s)
         next_under = 1'b0;
   end

   assign fall_event = next_under && !sys_under_flag && power_ready;

   always @(posedge sys_clk) begin
      if (rst) begin
         sys_threshold_sel <= `RSC_THR_RST;
         sys_fault_response <= `RSC_FRESP_RST;
         sys_under_flag <= 1'b0;
         power_ready <= 1'b0;
      end else begin
         if (sys_threshold_wr)
            sys_threshold_sel <= sys_threshold_wdata;
         if (sys_fault_response_wr)
            sys_fault_response <= sys_fault_response_wdata;
         sys_under_flag <= next_under;
         if (fall_event && !sys_fault_response)
            power_ready <= 1'b0;
         else if (rise_s && !below_s)
            power_ready <= 1'b1;
      end
   end

   // ==========================================================
   // Thermal gate, set beats cool-down
   always @(posedge sys_clk) begin
      if (rst)
         thermal_lock <= 1'b0;
      else if (hot_s)
         thermal_lock <= 1'b1;
      else if (cool_s)
         thermal_lock <= 1'b0;
   end

   // ==========================================================
   // Converter controls
   // Forced off is decoded from registered flags, so shutdown reaches buck_run
   // two cycles after the flag or lock changes, with no soft ramp-down.
   wire force_off;
   wire [`RSC_NBUCK-1:0] run_w;
   wire [`RSC_NBUCK-1:0] ss_w;

   assign force_off = !power_ready || thermal_lock;

   genvar gi;
   generate
      for (gi = 0; gi < `RSC_NBUCK; gi = gi + 1) begin : g_buck
         rsc_buck_ctrl #(
            .SS_CYCLES(SS_CYCLES)
         ) u_ctrl (
            .sys_clk(sys_clk),
            .rst(rst),
            .ms_tick(ms_tick),
            .enable_bit(buck_enable_bit[gi]),
            .delay_code(buck_delay_code[gi*DW +: DW]),
            .force_off(force_off),
            .buck_run(run_w[gi]),
            .soft_start(ss_w[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Output voltage banks and mode
   reg [`RSC_NBUCK*VW-1:0] vcode_low;
   reg [`RSC_NBUCK*VW-1:0] vcode_high;
   integer i;

   always @(posedge sys_clk) begin
      if (rst) begin
         vcode_low <= {`RSC_NBUCK{`RSC_VCODE_RST}};
         vcode_high <= {`RSC_NBUCK{`RSC_VCODE_RST}};
         forced_pwm <= {`RSC_NBUCK{`RSC_PWM_RST}};
         buck_vout_code <= {`RSC_NBUCK{`RSC_VCODE_RST}};
         buck_run <= {`RSC_NBUCK{1'b0}};
         buck_soft_start <= {`RSC_NBUCK{1'b0}};
      end else begin
         for (i = 0; i < `RSC_NBUCK; i = i + 1) begin
            // A write lands in whichever bank the synchronised pin bank_s selects
            if (vout_code_wr[i] && bank_s)
               vcode_high[i*VW +: VW] <= vout_code_wdata;
            else if (vout_code_wr[i])
               vcode_low[i*VW +: VW] <= vout_code_wdata;
            if (forced_pwm_wr[i])
               forced_pwm[i] <= forced_pwm_wdata;
         end
         buck_vout_code <= bank_s ? vcode_high : vcode_low;
         buck_run <= run_w;
         buck_soft_start <= ss_w;
      end
   end

   // ==========================================================
   // Interrupt sources and open-drain outputs
   reg sys_irq;
   reg next_sys_irq;
   reg [`RSC_NBUCK-1:0] pg_irq;
   reg [`RSC_NBUCK-1:0] next_pg_irq;
   reg [`RSC_NBUCK-1:0] pg_fall;
   integer j;

   always @* begin
      next_sys_irq = sys_irq;
      // Set wins over a read in the same cycle
      if (fall_event && sys_fault_response && sys_level_irq_unmask)
         next_sys_irq = 1'b1;
      else if (sys_flag_rd && !sys_under_flag && rise_s)
         next_sys_irq = 1'b0;
      pg_fall = pg_status & ~pg_s & buck_run;
      for (j = 0; j < `RSC_NBUCK; j = j + 1) begin
         next_pg_irq[j] = pg_irq[j];
         if (pg_fall[j] && fault_irq_unmask[j])
            next_pg_irq[j] = 1'b1;
         else if (pg_rd[j] && (!buck_run[j] || pg_s[j]))
            next_pg_irq[j] = 1'b0;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         sys_irq <= 1'b0;
         pg_irq <= {`RSC_NBUCK{1'b0}};
         pg_status <= {`RSC_NBUCK{1'b0}};
         int_request_n_out <= 1'b0;
         int_request_n_oe <= 1'b0;
         lowbat_flag_out_n_out <= 1'b0;
         lowbat_flag_out_n_oe <= 1'b0;
      end else begin
         sys_irq <= next_sys_irq;
         pg_irq <= next_pg_irq;
         pg_status <= pg_s;
         int_request_n_out <= 1'b0;
         int_request_n_oe <= next_sys_irq || (|next_pg_irq);
         lowbat_flag_out_n_out <= 1'b0;
         lowbat_flag_out_n_oe <= lowbat_s;
      end
   end

endmodule

// File: core/rsc_defs.vh
// Constants shared by the regulator supervisor control block
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

// ==========================================================
// Reset values
`define RSC_THR_RST 4'h7
`define RSC_FRESP_RST 1'b1
`define RSC_PWM_RST 1'b0
`define RSC_VCODE_RST 6'h18

// ==========================================================
// Timing
// Cycle counts at the 250 MHz system clock: 400 us ramp, 1 ms tick
`define RSC_SS_CYC 17'h186a0
`define RSC_MS_CYC 18'h3d090
`define RSC_SS_W 17
`define RSC_MS_W 18
`define RSC_DLY_W 8

// ==========================================================
// Field layout
`define RSC_NBUCK 3
`define RSC_VCODE_W 6
`define RSC_DCODE_W 3
`define RSC_NSYNC 9

`endif

// File: core/rsc_buck_ctrl.v
// Enable edge, turn-on delay and soft-start sequencing of one converter
`timescale 1ns/10ps
`include "rsc_defs.vh"

module rsc_buck_ctrl #(
   parameter [`RSC_SS_W-1:0] SS_CYCLES = `RSC_SS_CYC
) (
   input wire sys_clk,
   input wire rst,
   input wire ms_tick,
   input wire enable_bit,
   input wire [`RSC_DCODE_W-1:0] delay_code,
   input wire force_off,
   output reg buck_run,
   output reg soft_start
);

   localparam [1:0] ST_OFF = 2'b00;
   localparam [1:0] ST_DELAY = 2'b01;
   localparam [1:0] ST_RAMP = 2'b10;
   localparam [1:0] ST_ON = 2'b11;

   reg [1:0] state;
   reg [1:0] next_state;
   reg en_q;
   reg [`RSC_DLY_W-1:0] dly_cnt;
   reg [`RSC_DLY_W-1:0] next_dly_cnt;
   reg [`RSC_SS_W-1:0] ss_cnt;
   reg [`RSC_SS_W-1:0] next_ss_cnt;

   // ==========================================================
   // Delay in whole milliseconds for a code
   function [`RSC_DLY_W-1:0] delay_ms;
      input [`RSC_DCODE_W-1:0] code;
      begin
         if (code == {`RSC_DCODE_W{1'b0}})
            delay_ms = {`RSC_DLY_W{1'b0}};
         else
            delay_ms = {{(`RSC_DLY_W-1){1'b0}}, 1'b1} << code;
      end
   endfunction

   // ==========================================================
   // Sequencer
   always @* begin
      next_state = state;
      next_dly_cnt = dly_cnt;
      next_ss_cnt = ss_cnt;
      if (force_off) begin
         // Edges seen while forced off are dropped on purpose
         next_state = ST_OFF;
      end else if (en_q && !enable_bit) begin
         next_state = ST_OFF;
      end else if (!en_q && enable_bit) begin
         next_dly_cnt = {`RSC_DLY_W{1'b0}};
         next_ss_cnt = {`RSC_SS_W{1'b0}};
         if (delay_ms(delay_code) == {`RSC_DLY_W{1'b0}})
            next_state = ST_RAMP;
         else
            next_state = ST_DELAY;
      end else begin
         case (state)
            ST_DELAY: begin
               if (ms_tick) begin
                  next_dly_cnt = dly_cnt + {{(`RSC_DLY_W-1){1'b0}}, 1'b1};
                  if (next_dly_cnt == delay_ms(delay_code))
                     next_state = ST_RAMP;
               end
            end
            ST_RAMP: begin
               next_ss_cnt = ss_cnt + {{(`RSC_SS_W-1){1'b0}}, 1'b1};
               if (ss_cnt == SS_CYCLES - {{(`RSC_SS_W-1){1'b0}}, 1'b1})
                  next_state = ST_ON;
            end
            default: begin
               next_state = state;
            end
         endcase
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         state <= ST_OFF;
         en_q <= 1'b0;
         dly_cnt <= {`RSC_DLY_W{1'b0}};
         ss_cnt <= {`RSC_SS_W{1'b0}};
         buck_run <= 1'b0;
         soft_start <= 1'b0;
      end else begin
         state <= next_state;
         en_q <= enable_bit;
         dly_cnt <= next_dly_cnt;
         ss_cnt <= next_ss_cnt;
         buck_run <= (next_state == ST_RAMP) || (next_state == ST_ON);
         soft_start <= (next_state == ST_RAMP);
      end
   end

endmodule

// File: dv/rsc_checker.sv
// Port-level assertions for the supervisor block
`timescale 1ns/10ps
module rsc_checker #(
   parameter int SS_CYCLES = 20
) (
   input logic sys_clk,
   input logic rst,
   input logic sys_threshold_wr,
   input logic [3:0] sys_threshold_wdata,
   input logic [2:0] forced_pwm_wr,
   input logic forced_pwm_wdata,
   input logic [2:0] buck_enable_bit,
   input logic lowbat_sense_in,
   input logic [3:0] sys_threshold_sel,
   input logic sys_fault_response,
   input logic sys_under_flag,
   input logic thermal_lock,
   input logic [2:0] forced_pwm,
   input logic [2:0] buck_run,
   input logic [2:0] buck_soft_start,
   input logic int_request_n_out,
   input logic int_request_n_oe,
   input logic lowbat_flag_out_n_oe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // Ramp length counter
   logic [16:0] ss_cnt;
   always_ff @(posedge sys_clk)
      ss_cnt <= buck_soft_start[0] ? ss_cnt + 17'h1 : 17'h0;
   // ==========================================================
   // Assertions
   a_thr_write: assert property (
      sys_threshold_wr |=> sys_threshold_sel == $past(sys_threshold_wdata))
      else $error("threshold write lost");
   a_pwm_write: assert property (
      forced_pwm_wr[1] |=> forced_pwm[1] == $past(forced_pwm_wdata))
      else $error("pwm write lost");
   a_enable_fall: assert property (
      $fell(buck_enable_bit[0]) |-> ##2 !buck_run[0])
      else $error("converter kept running");
   a_start_ramp: assert property (
      $rose(buck_run[0]) |-> buck_soft_start[0])
      else $error("start without ramp");
   a_ramp_length: assert property (
      $fell(buck_soft_start[0]) && buck_run[0] |-> ss_cnt == SS_CYCLES)
      else $error("ramp length wrong");
   a_hot_hold: assert property (
      thermal_lock [*3] |-> buck_run == 3'h0)
      else $error("running while hot");
   a_uvlo_off: assert property (
      !sys_fault_response && $rose(sys_under_flag)
      |-> ##[0:3] buck_run == 3'h0)
      else $error("undervoltage did not stop converters");
   a_irq_low: assert property (
      int_request_n_oe |-> !int_request_n_out)
      else $error("interrupt not driven low");
   a_lowbat_follow: assert property (
      lowbat_sense_in [*4] |-> lowbat_flag_out_n_oe)
      else $error("low battery output idle");
   c_run: cover property ($rose(buck_run[0]));
   c_irq: cover property ($rose(int_request_n_oe));
   c_hot: cover property ($rose(thermal_lock));
endmodule

// File: dv/rsc_pg_model.sv
// Converter output model: power-good after a settling time
`timescale 1ns/10ps
module rsc_pg_model #(
   parameter SETTLE = 5
) (
   input wire sys_clk,
   input wire [2:0] buck_run,
   input wire [2:0] drop,
   output reg [2:0] pg_ok
);
   integer cnt [0:2];
   integer i;
   initial pg_ok = 3'h0;
   // Drop models an overload that the bench commands
   always @(posedge sys_clk) begin
      for (i = 0; i < 3; i = i + 1) begin
         cnt[i] <= buck_run[i] ? cnt[i] + 1 : 0;
         pg_ok[i] <= buck_run[i] && cnt[i] >= SETTLE && !drop[i];
      end
   end
endmodule

// File: dv/test_rsc_supervisor.sv
// Self-checking bench for the supervisor block
`timescale 1ns/10ps
module test_rsc_supervisor;
   reg sys_clk = 1'b0, rst = 1'b1, sys_below_fall = 1'b0;
   reg sys_above_rise = 1'b0, temp_over = 1'b0, temp_cooled = 1'b0;
   reg lowbat_sense_in = 1'b0, output_bank_select = 1'b0;
   reg sys_threshold_wr = 1'b0, sys_fault_response_wr = 1'b0;
   reg sys_fault_response_wdata = 1'b0, sys_level_irq_unmask = 1'b0;
   reg sys_flag_rd = 1'b0, forced_pwm_wdata = 1'b0;
   reg [3:0] sys_threshold_wdata = 4'h0;
   reg [2:0] buck_enable_bit = 3'h0, forced_pwm_wr = 3'h0;
   reg [2:0] vout_code_wr = 3'h0, fault_irq_unmask = 3'h0;
   reg [2:0] pg_rd = 3'h0, drop = 3'h0;
   reg [8:0] buck_delay_code = 9'h0;
   reg [5:0] vout_code_wdata = 6'h0;
   wire [2:0] pg_ok, pg_status, forced_pwm, buck_run, buck_soft_start;
   wire [3:0] sys_threshold_sel;
   wire [17:0] buck_vout_code;
   wire sys_fault_response, sys_under_flag, power_ready, thermal_lock;
   wire int_request_n_out, int_request_n_oe;
   wire lowbat_flag_out_n_out, lowbat_flag_out_n_oe;
   integer miscompares = 0, samples_checked = 0, cycles = 0;

   rsc_supervisor #(.SS_CYCLES(17'h14), .MS_CYCLES(18'ha)) u_dut (
      .sys_clk, .rst, .sys_below_fall, .sys_above_rise, .temp_over,
      .temp_cooled, .lowbat_sense_in, .pg_ok, .output_bank_select,
      .sys_threshold_wr, .sys_threshold_wdata, .sys_fault_response_wr,
      .sys_fault_response_wdata, .sys_level_irq_unmask, .sys_flag_rd,
      .buck_enable_bit, .buck_delay_code, .forced_pwm_wr,
      .forced_pwm_wdata, .vout_code_wr, .vout_code_wdata,
      .fault_irq_unmask, .pg_rd, .sys_threshold_sel, .sys_fault_response,
      .sys_under_flag, .power_ready, .thermal_lock, .pg_status,
      .forced_pwm, .buck_vout_code, .buck_run, .buck_soft_start,
      .int_request_n_out, .int_request_n_oe, .lowbat_flag_out_n_out,
      .lowbat_flag_out_n_oe);
   rsc_pg_model u_pg (.sys_clk, .buck_run, .drop, .pg_ok);

   always #2 sys_clk = ~sys_clk;
   // Whole run needs a few thousand cycles
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         results;
      end
   end
   // ==========================================================
   // Helpers
   task tick(input integer n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task chk(input [17:0] seen, input [17:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task en(input integer i, input v);
      buck_enable_bit[i] = v;
      tick(2);
   endtask
   task flag_read;
      sys_flag_rd = 1'b1;
      tick(1);
      sys_flag_rd = 1'b0;
      tick(2);
   endtask
   task resp_write(input v);
      sys_fault_response_wdata = v;
      sys_fault_response_wr = 1'b1;
      tick(1);
      sys_fault_response_wr = 1'b0;
      chk(sys_fault_response, v);
   endtask
   task results;
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task t_regs;
      integer k;
      chk(sys_threshold_sel, 4'h7);
      chk(sys_fault_response, 1'b1);
      chk(forced_pwm, 3'h0);
      chk(buck_vout_code, {3{6'h18}});
      chk(int_request_n_oe, 1'b0);
      for (k = 8; k < 24; k = k + 1) begin
         sys_threshold_wdata = k[3:0];
         sys_threshold_wr = 1'b1;
         tick(1);
         chk(sys_threshold_sel, k[3:0]);
      end
      sys_threshold_wr = 1'b0;
      forced_pwm_wdata = 1'b1;
      forced_pwm_wr = 3'h7;
      tick(1);
      forced_pwm_wdata = 1'b0;
      forced_pwm_wr = 3'h2;
      tick(1);
      forced_pwm_wr = 3'h0;
      chk(forced_pwm, 3'h5);
      vout_code_wdata = 6'h0a;
      vout_code_wr = 3'h1;
      tick(1);
      vout_code_wr = 3'h0;
      output_bank_select = 1'b1;
      tick(4);
      vout_code_wdata = 6'h33;
      vout_code_wr = 3'h1;
      tick(1);
      vout_code_wr = 3'h0;
      // Bank register lands first, the selected code one edge later
      tick(1);
      chk(buck_vout_code[5:0], 6'h33);
      output_bank_select = 1'b0;
      tick(4);
      chk(buck_vout_code[5:0], 6'h0a);
   endtask
   task t_enable;
      integer c, n;
      chk(power_ready, 1'b0);
      sys_above_rise = 1'b1;
      tick(4);
      chk(power_ready, 1'b1);
      en(0, 1'b1);
      chk(buck_run[0], 1'b1);
      chk(buck_soft_start[0], 1'b1);
      tick(22);
      chk(buck_soft_start[0], 1'b0);
      for (c = 1; c < 8; c = c + 1) begin
         buck_delay_code[8:6] = c[2:0];
         buck_enable_bit[2] = 1'b1;
         n = 0;
         while (buck_run[2] !== 1'b1 && n < 1400) begin
            tick(1);
            n = n + 1;
         end
         chk(n >= ((1 << c) - 1) * 10 - 1 && n <= (1 << c) * 10 + 3, 1);
         en(2, 1'b0);
         chk(buck_run[2], 1'b0);
      end
   endtask
   task t_pg_irq;
      fault_irq_unmask = 3'h1;
      drop[0] = 1'b1;
      tick(6);
      chk(pg_status[0], 1'b0);
      chk(int_request_n_oe, 1'b1);
      pg_rd = 3'h1;
      tick(1);
      pg_rd = 3'h0;
      drop[0] = 1'b0;
      tick(6);
      chk(int_request_n_oe, 1'b1);
      pg_rd = 3'h1;
      tick(1);
      pg_rd = 3'h0;
      tick(2);
      chk(int_request_n_oe, 1'b0);
      fault_irq_unmask = 3'h0;
   endtask
   task t_sys;
      sys_level_irq_unmask = 1'b1;
      sys_above_rise = 1'b0;
      sys_below_fall = 1'b1;
      tick(5);
      chk(sys_under_flag, 1'b1);
      chk(int_request_n_oe, 1'b1);
      chk(buck_run[0], 1'b1);
      flag_read;
      chk(int_request_n_oe, 1'b1);
      sys_below_fall = 1'b0;
      tick(5);
      chk(sys_under_flag, 1'b1);
      sys_above_rise = 1'b1;
      tick(5);
      chk(sys_under_flag, 1'b0);
      chk(int_request_n_oe, 1'b1);
      flag_read;
      chk(int_request_n_oe, 1'b0);
      resp_write(1'b0);
      sys_above_rise = 1'b0;
      sys_below_fall = 1'b1;
      tick(6);
      chk(buck_run, 3'h0);
      chk(int_request_n_oe, 1'b0);
      sys_below_fall = 1'b0;
      sys_above_rise = 1'b1;
      tick(5);
      chk(power_ready, 1'b1);
      resp_write(1'b1);
   endtask
   task t_hot;
      en(0, 1'b0);
      en(0, 1'b1);
      temp_over = 1'b1;
      tick(5);
      chk(thermal_lock, 1'b1);
      chk(buck_run[0], 1'b0);
      temp_over = 1'b0;
      en(0, 1'b0);
      en(0, 1'b1);
      chk(buck_run[0], 1'b0);
      temp_cooled = 1'b1;
      tick(4);
      temp_cooled = 1'b0;
      chk(thermal_lock, 1'b0);
      en(0, 1'b0);
      en(0, 1'b1);
      chk(buck_run[0], 1'b1);
      lowbat_sense_in = 1'b1;
      tick(4);
      chk(lowbat_flag_out_n_oe, 1'b1);
      chk(lowbat_flag_out_n_out, 1'b0);
      lowbat_sense_in = 1'b0;
      tick(4);
      chk(lowbat_flag_out_n_oe, 1'b0);
   endtask

   initial begin
      tick(16);
      rst = 1'b0;
      t_regs;
      t_enable;
      t_pg_irq;
      t_sys;
      t_hot;
      results;
   end
endmodule

bind rsc_supervisor rsc_checker #(.SS_CYCLES(SS_CYCLES)) u_chk (
   .sys_clk, .rst, .sys_threshold_wr, .sys_threshold_wdata,
   .forced_pwm_wr, .forced_pwm_wdata, .buck_enable_bit, .lowbat_sense_in,
   .sys_threshold_sel, .sys_fault_response, .sys_under_flag,
   .thermal_lock, .forced_pwm, .buck_run, .buck_soft_start,
   .int_request_n_out, .int_request_n_oe, .lowbat_flag_out_n_oe);
